/* rtl/core_state_flags.sv */
// Core stack pointer, instruction pointer, flags and sequencing
// Function
// RQ1: Reset loads stack pointer with 00FF.
// RQ2: Stack low reload sets low byte FF.
// RQ3: Push decrements, pull increments stack pointer.
// RQ4: Stack-relative address is stack pointer plus offset.
// RQ5: Instruction pointer advances; jumps/interrupts load it.
// RQ6: Reset fetches start address from FFFE/FFFF.
// RQ7: Flag bits 6 and 5 read one always.
// RQ8: Overflow flag tracks two's complement overflow.
// RQ9: Half carry from bit 3 on adds.
// RQ10: Mask blocks interrupts; set after stacking.
// RQ11: Interrupt entry never stacks index high byte.
// RQ12: Highest priority pending request served first.
// RQ13: Return restores flags; reset masks; unmask clears.
// RQ14: Negative flag copies result bit 7.
// RQ15: Zero flag set on zero result.
// RQ16: Carry on add carry or subtract borrow.
// RQ17: Wait clears mask, gates core clock.
// RQ18: Stop clears mask; restart after stabilisation delay.
// RQ19: Break loads trap opcode, vector by mode.
// RQ20: Break starts after instruction's final cycle.
// RQ21: Break ends on return once request drops.
// RQ22: Signed immediate adds, flags untouched.
// RQ23: Stop is illegal unless enabled.
// RQ24: Flag layout V - - H I N Z C.
`timescale 1ns/100ps
`include "core_state_regs.svh"
module core_state_flags import core_state_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire wb_req_s wb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire cmd_s cmd_in,
  input wire alu_s alu_in,
  input wire logic [7:0] acc_in,
  input wire logic [15:0] idx_in,
  input wire logic [3:0] irq_req_in,
  input wire logic brk_req_in,
  input wire logic instr_last_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [15:0] stack_ptr_out,
  output logic [15:0] instr_pointer_out,
  output logic [7:0] flag_register_out,
  output logic [15:0] oper_addr_out,
  output logic [15:0] idx_sum_out,
  output logic [7:0] alu_res_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_we_out,
  output logic mem_re_out,
  output logic core_clk_en_out,
  output logic ir_load_out,
  output logic [7:0] ir_value_out,
  output logic illegal_op_out,
  output logic in_break_out
);

  function automatic logic [15:0] sext16(input logic [7:0] b);
    sext16 = {{8{b[7]}}, b};
  endfunction : sext16

  // Lowest request index has the highest priority
  function automatic logic [1:0] prio_idx(input logic [3:0] r);
    prio_idx = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (r[i]) begin
        prio_idx = 2'(i);
      end
    end
  endfunction : prio_idx

  state_e state;
  state_e next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [12:0] rec_cnt;
  logic [12:0] next_rec_cnt;
  logic [15:0] vec_base;
  logic [15:0] next_vec_base;
  logic [7:0] vec_hi;
  logic [7:0] next_vec_hi;
  logic [2:0] cfg;
  logic [2:0] next_cfg;
  logic brk_pend;
  logic next_brk_pend;
  logic [15:0] next_sp;
  logic [15:0] next_ip;
  logic [7:0] next_flags;
  logic [15:0] next_oper_addr;
  logic [15:0] next_idx_sum;
  logic [7:0] next_alu_res;
  logic [15:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic next_mem_we;
  logic next_mem_re;
  logic next_clk_en;
  logic next_ir_load;
  logic [7:0] next_ir_value;
  logic next_illegal;
  logic next_in_break;
  logic [31:0] next_wb_dat;
  logic next_wb_ack;

  logic [8:0] sum;
  logic [4:0] hsum;
  logic cin;
  logic [7:0] res;
  logic take_brk;
  logic take_irq;
  logic bus_hit;
  logic [15:0] wr16;
  logic [31:0] rd_word;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rec_cnt = rec_cnt;
    next_vec_base = vec_base;
    next_vec_hi = vec_hi;
    next_cfg = cfg;
    next_brk_pend = brk_pend;
    next_sp = stack_ptr_out;
    next_ip = instr_pointer_out;
    next_flags = flag_register_out;
    next_oper_addr = oper_addr_out;
    next_idx_sum = idx_sum_out;
    next_alu_res = alu_res_out;
    next_mem_addr = mem_addr_out;
    next_mem_wdata = mem_wdata_out;
    next_mem_we = 1'b0;
    next_mem_re = 1'b0;
    next_clk_en = core_clk_en_out;
    next_ir_load = 1'b0;
    next_ir_value = ir_value_out;
    next_illegal = 1'b0;
    next_in_break = in_break_out;
    sum = 9'h000;
    hsum = 5'h00;
    cin = flag_register_out[`FLAG_C];
    res = 8'h00;
    // Break request is remembered until an instruction boundary
    if (brk_req_in && !in_break_out) begin
      next_brk_pend = 1'b1;
    end
    take_brk = (brk_req_in || brk_pend) && !in_break_out && instr_last_in; // see RQ20
    take_irq = (|irq_req_in) && !flag_register_out[`FLAG_I] && instr_last_in; // see RQ10

    case (state)
      ST_VEC_A: begin
        next_mem_addr = vec_base + 16'h0001;
        next_mem_re = 1'b1;
        next_state = ST_VEC_B;
      end
      ST_VEC_B: begin
        next_vec_hi = mem_rdata_in;
        next_state = ST_VEC_C;
      end
      ST_VEC_C: begin
        next_ip = {vec_hi, mem_rdata_in}; // see RQ6
        next_state = ST_RUN;
      end
      ST_STACK: begin
        // Frame holds IP low, IP high, index low, acc, flags: no index high
        next_mem_addr = stack_ptr_out;
        next_mem_we = 1'b1;
        case (cnt)
          3'h0: next_mem_wdata = instr_pointer_out[7:0];
          3'h1: next_mem_wdata = instr_pointer_out[15:8];
          3'h2: next_mem_wdata = idx_in[7:0]; // see RQ11
          3'h3: next_mem_wdata = acc_in;
          default: next_mem_wdata = flag_register_out;
        endcase
        next_sp = stack_ptr_out - 16'h0001; // see RQ3
        next_cnt = cnt + 3'h1;
        if (cnt == `STACK_LAST) begin
          next_flags[`FLAG_I] = 1'b1; // see RQ10
          next_mem_addr = vec_base;
          next_mem_re = 1'b1;
          next_state = ST_VEC_A;
        end
      end
      ST_PULL: begin
        if (cnt < `PULL_LAST - 3'h1) begin // Data trails its address by two edges
          next_sp = stack_ptr_out + 16'h0001; // see RQ3
          next_mem_addr = stack_ptr_out + 16'h0001;
          next_mem_re = 1'b1;
        end
        case (cnt)
          3'h2: next_flags = mem_rdata_in | `FLAG_ONES; // see RQ13
          3'h5: next_vec_hi = mem_rdata_in;
          `PULL_LAST: next_ip = {vec_hi, mem_rdata_in};
          default: next_flags = flag_register_out;
        endcase
        next_cnt = cnt + 3'h1;
        if (cnt == `PULL_LAST) begin
          if (in_break_out && !brk_req_in) begin
            next_in_break = 1'b0; // see RQ21
          end
          next_state = ST_RUN;
        end
      end
      ST_WAIT: begin
        // Interrupt wake stacks the frame, which sets the mask; reset sets it
        if (|irq_req_in) begin
          next_clk_en = 1'b1; // see RQ17
          next_vec_base = `VEC_IRQ_TOP - {13'h0000, prio_idx(irq_req_in), 1'b0};
          next_cnt = 3'h0;
          next_state = ST_STACK;
        end
      end
      ST_STOP: begin
        if (|irq_req_in) begin
          next_rec_cnt = cfg[`CFG_SHORT_STOP] ? `STOP_SHORT_CYC : `STOP_LONG_CYC;
          next_vec_base = `VEC_IRQ_TOP - {13'h0000, prio_idx(irq_req_in), 1'b0};
          next_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // Core clock held off until the oscillator has settled
        next_rec_cnt = rec_cnt - 13'h0001;
        if (rec_cnt == 13'h0001) begin
          next_clk_en = 1'b1; // see RQ18
          next_cnt = 3'h0;
          next_state = ST_STACK;
        end
      end
      ST_RUN: begin
        case (cmd_in.op)
          CMD_FETCH: next_ip = instr_pointer_out + 16'h0001; // see RQ5
          CMD_LOAD_IP: next_ip = cmd_in.data16; // see RQ5
          CMD_PUSH: next_sp = stack_ptr_out - 16'h0001; // see RQ3
          CMD_PULL: next_sp = stack_ptr_out + 16'h0001; // see RQ3
          CMD_STACK_RELOAD: next_sp = {stack_ptr_out[15:8], `SP_LOW_RELOAD}; // see RQ2
          CMD_ADD_SP: next_sp = stack_ptr_out + sext16(cmd_in.imm8); // see RQ22
          CMD_ADD_IDX: next_idx_sum = idx_in + sext16(cmd_in.imm8); // see RQ22
          CMD_SP_ADDR8: next_oper_addr = stack_ptr_out + {8'h00, cmd_in.imm8}; // see RQ4
          CMD_SP_ADDR16: next_oper_addr = stack_ptr_out + cmd_in.data16; // see RQ4
          CMD_UNMASK: next_flags[`FLAG_I] = 1'b0; // see RQ13
          CMD_WRITE_FLAGS: next_flags = cmd_in.imm8 | `FLAG_ONES; // see RQ7
          CMD_WAIT: begin
            next_flags[`FLAG_I] = 1'b0; // see RQ17
            next_clk_en = 1'b0;
            next_state = ST_WAIT;
          end
          CMD_STOP: begin
            if (cfg[`CFG_STOP_EN]) begin
              next_flags[`FLAG_I] = 1'b0; // see RQ18
              next_clk_en = 1'b0;
              next_state = ST_STOP;
            end else begin
              next_illegal = 1'b1; // see RQ23
            end
          end
          CMD_RETURN: begin
            next_cnt = 3'h0;
            next_state = ST_PULL;
          end
          CMD_ALU: begin
            case (alu_in.op)
              ALU_ADD, ALU_ADC: begin
                if (alu_in.op == ALU_ADD) begin
                  cin = 1'b0;
                end
                sum = {1'b0, alu_in.a} + {1'b0, alu_in.m} + {8'h00, cin};
                hsum = {1'b0, alu_in.a[3:0]} + {1'b0, alu_in.m[3:0]} + {4'h0, cin};
                res = sum[7:0];
                next_flags[`FLAG_H] = hsum[4]; // see RQ9
                next_flags[`FLAG_C] = sum[8]; // see RQ16
                next_flags[`FLAG_V] = (alu_in.a[7] == alu_in.m[7]) && (res[7] != alu_in.a[7]); // see RQ8
              end
              ALU_SUB, ALU_SBC: begin
                if (alu_in.op == ALU_SUB) begin
                  cin = 1'b0;
                end
                sum = {1'b0, alu_in.a} - {1'b0, alu_in.m} - {8'h00, cin};
                res = sum[7:0];
                next_flags[`FLAG_C] = sum[8]; // see RQ16
                next_flags[`FLAG_V] = (alu_in.a[7] != alu_in.m[7]) && (res[7] != alu_in.a[7]); // see RQ8
              end
              ALU_SHIFT: begin
                res = alu_in.res;
                next_flags[`FLAG_C] = alu_in.sh_c; // see RQ16
                next_flags[`FLAG_V] = alu_in.res[7] ^ alu_in.sh_c; // see RQ8
              end
              default: begin
                res = alu_in.res;
                next_flags[`FLAG_V] = 1'b0; // see RQ8
              end
            endcase
            next_flags[`FLAG_N] = res[7]; // see RQ14
            next_flags[`FLAG_Z] = (res == 8'h00); // see RQ15
            next_alu_res = res;
          end
          default: next_ip = instr_pointer_out;
        endcase
        // Break outranks maskable requests at an instruction boundary
        if (cmd_in.op != CMD_WAIT && cmd_in.op != CMD_STOP && cmd_in.op != CMD_RETURN) begin
          if (take_brk) begin
            next_ir_load = 1'b1; // see RQ19
            next_ir_value = `SOFT_TRAP_OPCODE;
            next_in_break = 1'b1;
            next_brk_pend = 1'b0;
            next_vec_base = cfg[`CFG_MONITOR] ? `VEC_BRK_MON : `VEC_BRK; // see RQ19
            next_cnt = 3'h0;
            next_state = ST_STACK;
          end else if (take_irq) begin
            next_vec_base = `VEC_IRQ_TOP - {13'h0000, prio_idx(irq_req_in), 1'b0}; // see RQ12
            next_cnt = 3'h0;
            next_state = ST_STACK;
          end
        end
      end
      default: next_state = ST_RUN;
    endcase

    // Bus writes win over the core in the same cycle
    bus_hit = wb_in.cyc && wb_in.stb && !wb_ack_out;
    next_wb_ack = bus_hit;
    wr16 = {wb_in.sel[1] ? wb_in.dat[15:8] : 8'h00, wb_in.sel[0] ? wb_in.dat[7:0] : 8'h00};
    case (wb_in.adr)
      `OFS_STACK: rd_word = {16'h0000, stack_ptr_out};
      `OFS_IPTR: rd_word = {16'h0000, instr_pointer_out};
      `OFS_FLAGS: rd_word = {24'h000000, flag_register_out};
      `OFS_CFG: rd_word = {29'h00000000, cfg};
      `OFS_STATUS: rd_word = {24'h000000, in_break_out, brk_pend, core_clk_en_out,
                              1'b0, 4'(state)};
      default: rd_word = 32'h00000000;
    endcase
    next_wb_dat = bus_hit && !wb_in.we ? rd_word : 32'h00000000;
    if (bus_hit && wb_in.we) begin
      case (wb_in.adr)
        `OFS_STACK: begin
          if (wb_in.sel[0]) next_sp[7:0] = wr16[7:0];
          if (wb_in.sel[1]) next_sp[15:8] = wr16[15:8];
        end
        `OFS_IPTR: begin
          if (wb_in.sel[0]) next_ip[7:0] = wr16[7:0];
          if (wb_in.sel[1]) next_ip[15:8] = wr16[15:8];
        end
        `OFS_FLAGS: begin
          if (wb_in.sel[0]) next_flags = wr16[7:0] | `FLAG_ONES; // see RQ7
        end
        `OFS_CFG: begin
          if (wb_in.sel[0]) next_cfg = wb_in.dat[2:0];
        end
        default: next_cfg = next_cfg;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_VEC_A;
      cnt <= 3'h0;
      rec_cnt <= 13'h0000;
      vec_base <= `VEC_RESET; // see RQ6
      vec_hi <= 8'h00;
      cfg <= `CFG_RESET;
      brk_pend <= 1'b0;
      stack_ptr_out <= `SP_RESET; // see RQ1
      instr_pointer_out <= 16'h0000;
      flag_register_out <= `FLAG_RESET; // see RQ13
      oper_addr_out <= 16'h0000;
      idx_sum_out <= 16'h0000;
      alu_res_out <= 8'h00;
      mem_addr_out <= `VEC_RESET;
      mem_wdata_out <= 8'h00;
      mem_we_out <= 1'b0;
      mem_re_out <= 1'b1;
      core_clk_en_out <= 1'b1;
      ir_load_out <= 1'b0;
      ir_value_out <= 8'h00;
      illegal_op_out <= 1'b0;
      in_break_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
      wb_ack_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rec_cnt <= next_rec_cnt;
      vec_base <= next_vec_base;
      vec_hi <= next_vec_hi;
      cfg <= next_cfg;
      brk_pend <= next_brk_pend;
      stack_ptr_out <= next_sp;
      instr_pointer_out <= next_ip;
      flag_register_out <= next_flags | `FLAG_ONES; // see RQ24
      oper_addr_out <= next_oper_addr;
      idx_sum_out <= next_idx_sum;
      alu_res_out <= next_alu_res;
      mem_addr_out <= next_mem_addr;
      mem_wdata_out <= next_mem_wdata;
      mem_we_out <= next_mem_we;
      mem_re_out <= next_mem_re;
      core_clk_en_out <= next_clk_en;
      ir_load_out <= next_ir_load;
      ir_value_out <= next_ir_value;
      illegal_op_out <= next_illegal;
      in_break_out <= next_in_break;
      wb_dat_out <= next_wb_dat;
      wb_ack_out <= next_wb_ack;
    end
  end

endmodule : core_state_flags

/* rtl/core_state_pkg.sv */
// Types shared by the core state and flags block
package core_state_pkg;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_FETCH, CMD_LOAD_IP, CMD_PUSH, CMD_PULL, CMD_STACK_RELOAD,
    CMD_ADD_SP, CMD_ADD_IDX, CMD_SP_ADDR8, CMD_SP_ADDR16, CMD_ALU,
    CMD_UNMASK, CMD_WRITE_FLAGS, CMD_WAIT, CMD_STOP, CMD_RETURN
  } cmd_e;
  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_LOGIC, ALU_SHIFT
  } alu_op_e;
  typedef enum {
    ST_VEC_A, ST_VEC_B, ST_VEC_C, ST_RUN, ST_STACK, ST_PULL,
    ST_WAIT, ST_STOP, ST_RECOVER
  } state_e;
  typedef struct packed {
    cmd_e op;
    logic [7:0] imm8;
    logic [15:0] data16;
  } cmd_s;
  typedef struct packed {
    alu_op_e op;
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] res;
    logic sh_c;
  } alu_s;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;
endpackage : core_state_pkg

/* rtl/core_state_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CORE_STATE_REGS_SVH
`define CORE_STATE_REGS_SVH
`define OFS_STACK 8'h00
`define OFS_IPTR 8'h04
`define OFS_FLAGS 8'h08
`define OFS_CFG 8'h0C
`define OFS_STATUS 8'h10
`define CFG_STOP_EN 0
`define CFG_SHORT_STOP 1
`define CFG_MONITOR 2
`define CFG_RESET 3'h1
`define SP_RESET 16'h00FF
`define SP_LOW_RELOAD 8'hFF
`define VEC_RESET 16'hFFFE
`define VEC_BRK 16'hFFFC
`define VEC_BRK_MON 16'hFEFC
`define VEC_IRQ_TOP 16'hFFFA
`define FLAG_V 7
`define FLAG_H 4
`define FLAG_I 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define FLAG_ONES 8'h60
`define FLAG_RESET 8'h68
`define SOFT_TRAP_OPCODE 8'h83
`define STACK_LAST 3'h4
`define PULL_LAST 3'h6
`define STOP_LONG_CYC 13'h1000
`define STOP_SHORT_CYC 13'h0020
`endif

/* verif/core_state_flags_chk.sv */
// Checker for the core state and flags block, bound to its ports
`timescale 1ns/100ps
`include "core_state_regs.svh"
module core_state_flags_chk import core_state_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire wb_req_s wb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire cmd_s cmd_in,
  input wire alu_s alu_in,
  input wire logic [15:0] idx_in,
  input wire logic [15:0] stack_ptr_out,
  input wire logic [7:0] flag_register_out,
  input wire logic [15:0] idx_sum_out,
  input wire logic [7:0] alu_res_out,
  input wire logic ir_load_out,
  input wire logic [7:0] ir_value_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic quiet;
  logic [15:0] sum_exp;
  logic [15:0] next_sum_exp;
  // A bus write in the same cycle would win over the command
  assign quiet = !(wb_in.cyc && wb_in.stb);
  always_comb begin
    next_sum_exp = idx_in + {{8{cmd_in.imm8[7]}}, cmd_in.imm8};
  end
  always_ff @(posedge clk_in) begin
    sum_exp <= next_sum_exp;
  end
  sequence bus_req;
    wb_in.cyc && wb_in.stb && !wb_ack_out;
  endsequence
  sequence ack_once;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  bus_answer_a: assert property (bus_req |=> ack_once)
    else $error("request not answered by a single ack");
  idle_data_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero outside ack");
  reset_state_a: assert property ($rose(nrst_in) |->
    stack_ptr_out == `SP_RESET && flag_register_out == `FLAG_RESET)
    else $error("wrong state after reset");
  fixed_ones_a: assert property (flag_register_out[6:5] == 2'b11)
    else $error("flag bits 6 and 5 not one");
  low_reload_a: assert property (quiet && cmd_in.op == CMD_STACK_RELOAD |=>
    $stable(stack_ptr_out[15:8]) && stack_ptr_out[7:0] == `SP_LOW_RELOAD)
    else $error("stack low reload wrong");
  push_step_a: assert property (quiet && cmd_in.op == CMD_PUSH |=>
    stack_ptr_out == $past(stack_ptr_out) - 16'h0001)
    else $error("push did not decrement stack");
  signed_add_a: assert property (quiet && cmd_in.op == CMD_ADD_IDX |=>
    idx_sum_out == sum_exp)
    else $error("signed index add wrong");
  flags_kept_a: assert property (quiet && cmd_in.op inside {CMD_ADD_SP, CMD_ADD_IDX} |=>
    $stable(flag_register_out))
    else $error("signed add changed flags");
  alu_add_a: assert property (quiet && cmd_in.op == CMD_ALU && alu_in.op == ALU_ADD |=>
    alu_res_out == 8'($past(alu_in.a) + $past(alu_in.m)) &&
    flag_register_out[`FLAG_N] == alu_res_out[7] &&
    flag_register_out[`FLAG_Z] == (alu_res_out == 8'h00))
    else $error("add result or flags wrong");
  trap_value_a: assert property (ir_load_out |->
    ir_value_out == `SOFT_TRAP_OPCODE ##1 !ir_load_out)
    else $error("trap opcode load wrong");
endmodule : core_state_flags_chk
bind core_state_flags core_state_flags_chk chk_u (.clk_in, .nrst_in, .wb_in, .wb_dat_out,
  .wb_ack_out, .cmd_in, .alu_in, .idx_in, .stack_ptr_out, .flag_register_out, .idx_sum_out,
  .alu_res_out, .ir_load_out, .ir_value_out);

/* verif/cpu_core_state_and_flags_bench.sv */
// Self-checking bench for the core state and flags block
`timescale 1ns/100ps
`include "core_state_regs.svh"
module cpu_core_state_and_flags_bench import core_state_pkg::*;;
  typedef struct {alu_op_e op; logic [7:0] a, m, res, flags;} alu_case_s;
  logic clk_in = 1'b0, nrst_in = 1'b0, brk_req_in = 1'b0, instr_last_in = 1'b1;
  wb_req_s wb_in = '0;
  cmd_s cmd_in = '0;
  alu_s alu_in = '0;
  logic [7:0] acc_in = 8'h00, mem_rdata_in = 8'h00;
  logic [15:0] idx_in = 16'h1000;
  logic [3:0] irq_req_in = 4'h0;
  logic [31:0] wb_dat_out, rd;
  logic wb_ack_out, mem_we_out, mem_re_out, core_clk_en_out, ir_load_out;
  logic illegal_op_out, in_break_out;
  logic [15:0] stack_ptr_out, instr_pointer_out, oper_addr_out, idx_sum_out, mem_addr_out;
  logic [7:0] flag_register_out, alu_res_out, mem_wdata_out, ir_value_out;
  int n_fail = 0, n_tests = 0, cycles = 0, n_we = 0, n_ill = 0, we0, k;
  // Carry feeds from one row to the next, so the order matters
  alu_case_s alu_tab [7] = '{'{ALU_ADD, 8'h7F, 8'h01, 8'h80, 8'hFC},
    '{ALU_ADD, 8'h80, 8'h80, 8'h00, 8'hEB}, '{ALU_ADC, 8'h0F, 8'h00, 8'h10, 8'h78},
    '{ALU_SUB, 8'h00, 8'h01, 8'hFF, 8'h7D}, '{ALU_SHIFT, 8'h40, 8'h00, 8'h80, 8'h7D},
    '{ALU_LOGIC, 8'h00, 8'h00, 8'h00, 8'h7B}, '{ALU_SBC, 8'h10, 8'h0F, 8'h00, 8'h7A}};
  always #20 clk_in = ~clk_in;
  core_state_flags dut_u (.clk_in, .nrst_in, .wb_in, .wb_dat_out, .wb_ack_out, .cmd_in,
    .alu_in, .acc_in, .idx_in, .irq_req_in, .brk_req_in, .instr_last_in, .mem_rdata_in,
    .stack_ptr_out, .instr_pointer_out, .flag_register_out, .oper_addr_out, .idx_sum_out,
    .alu_res_out, .mem_addr_out, .mem_wdata_out, .mem_we_out, .mem_re_out,
    .core_clk_en_out, .ir_load_out, .ir_value_out, .illegal_op_out, .in_break_out);
  // Memory answers a one-cycle-late byte: low address byte XOR high address byte
  always @(posedge clk_in) begin
    mem_rdata_in <= mem_addr_out[7:0] ^ mem_addr_out[15:8];
    n_we <= n_we + int'(mem_we_out === 1'b1);
    n_ill <= n_ill + int'(illegal_op_out === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_in);
    wb_in <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    k = 0;
    while (wb_ack_out !== 1'b1) begin
      @(posedge clk_in);
      k++;
    end
    rd = wb_dat_out;
    chk("bus ack delay", 2, k);
    wb_in <= '0;
  endtask : bus
  task automatic cmd(input cmd_e op, input logic [7:0] imm, input logic [15:0] d16,
      input alu_s al);
    @(posedge clk_in);
    cmd_in <= '{op: op, imm8: imm, data16: d16};
    alu_in <= al;
    @(posedge clk_in);
    cmd_in <= '0;
    #1;
  endtask : cmd
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    chk("start address", 16'h0100, instr_pointer_out);
    chk("stack reset", 16'h00FF, stack_ptr_out);
    chk("flag reset", 8'h68, flag_register_out);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, rd);
    bus(1'b1, `OFS_FLAGS, 32'h0);
    bus(1'b0, `OFS_FLAGS, 32'h0);
    chk("flags read", 32'h60, rd);
    bus(1'b1, `OFS_FLAGS, 32'h68);
    bus(1'b1, `OFS_STACK, 32'h1234);
    bus(1'b0, `OFS_STACK, 32'h0);
    chk("stack read", 16'h1234, rd[15:0]);
    cmd(CMD_STACK_RELOAD, 8'h00, 16'h0, '0);
    chk("stack reload", 16'h12FF, stack_ptr_out);
    cmd(CMD_PUSH, 8'h00, 16'h0, '0);
    chk("push", 16'h12FE, stack_ptr_out);
    cmd(CMD_PULL, 8'h00, 16'h0, '0);
    chk("pull", 16'h12FF, stack_ptr_out);
    cmd(CMD_SP_ADDR8, 8'h10, 16'h0, '0);
    chk("offset8 address", 16'h130F, oper_addr_out);
    cmd(CMD_SP_ADDR16, 8'h00, 16'h0100, '0);
    chk("offset16 address", 16'h13FF, oper_addr_out);
    cmd(CMD_ADD_SP, 8'h80, 16'h0, '0);
    chk("signed stack add", 16'h127F, stack_ptr_out);
    cmd(CMD_ADD_IDX, 8'hFF, 16'h0, '0);
    chk("signed index add", 16'h0FFF, idx_sum_out);
    chk("flags after adds", 8'h68, flag_register_out);
    cmd(CMD_LOAD_IP, 8'h00, 16'h4000, '0);
    chk("jump address", 16'h4000, instr_pointer_out);
    cmd(CMD_FETCH, 8'h00, 16'h0, '0);
    chk("fetch advance", 16'h4001, instr_pointer_out);
    foreach (alu_tab[i]) begin
      cmd(CMD_ALU, 8'h00, 16'h0, '{alu_tab[i].op, alu_tab[i].a, alu_tab[i].m,
        alu_tab[i].res, 1'b1});
      chk("alu result", alu_tab[i].res, alu_res_out);
      chk("alu flags", alu_tab[i].flags, flag_register_out);
    end
    cmd(CMD_WRITE_FLAGS, 8'h9F, 16'h0, '0);
    chk("flags write", 8'hFF, flag_register_out);
    cmd(CMD_UNMASK, 8'h00, 16'h0, '0);
    chk("mask cleared", 0, flag_register_out[`FLAG_I]);
    we0 = n_we;
    @(posedge clk_in);
    irq_req_in <= 4'h6;
    for (k = 0; k < 40 && instr_pointer_out !== 16'h0706; k++) @(posedge clk_in);
    irq_req_in <= 4'h0;
    chk("priority vector", 16'h0706, instr_pointer_out);
    chk("mask after entry", 1, flag_register_out[`FLAG_I]);
    chk("stacked bytes", 5, n_we - we0);
    chk("stack after entry", 16'h127A, stack_ptr_out);
    cmd(CMD_RETURN, 8'h00, 16'h0, '0);
    for (k = 0; k < 20 && instr_pointer_out !== 16'h6C6D; k++) @(posedge clk_in);
    #1;
    chk("return address", 16'h6C6D, instr_pointer_out);
    chk("stack after return", 16'h127F, stack_ptr_out);
    chk("restored flags", 8'h69, flag_register_out);
    bus(1'b1, `OFS_CFG, 32'h4);
    brk_req_in <= 1'b1;
    instr_last_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("break waits", 0, ir_load_out);
    brk_req_in <= 1'b0;
    instr_last_in <= 1'b1;
    for (k = 0; k < 20 && ir_load_out !== 1'b1; k++) @(posedge clk_in);
    chk("trap opcode", 8'h83, ir_value_out);
    brk_req_in <= 1'b0;
    for (k = 0; k < 40 && instr_pointer_out !== 16'h0203; k++) @(posedge clk_in);
    chk("monitor vector", 16'h0203, instr_pointer_out);
    chk("in break", 1, in_break_out);
    cmd(CMD_RETURN, 8'h00, 16'h0, '0);
    for (k = 0; k < 20 && in_break_out !== 1'b0; k++) @(posedge clk_in);
    chk("break ended", 0, in_break_out);
    cmd(CMD_STOP, 8'h00, 16'h0, '0);
    @(posedge clk_in);
    #1;
    chk("stop refused", 1, n_ill);
    cmd(CMD_WAIT, 8'h00, 16'h0, '0);
    chk("wait clock", 0, core_clk_en_out);
    chk("wait mask", 0, flag_register_out[`FLAG_I]);
    @(posedge clk_in);
    irq_req_in <= 4'h1;
    for (k = 0; k < 40 && instr_pointer_out !== 16'h0504; k++) @(posedge clk_in);
    irq_req_in <= 4'h0;
    chk("wake vector", 16'h0504, instr_pointer_out);
    bus(1'b1, `OFS_CFG, 32'h3);
    cmd(CMD_STOP, 8'h00, 16'h0, '0);
    chk("stop clock", 0, core_clk_en_out);
    @(posedge clk_in);
    irq_req_in <= 4'h1;
    for (k = 0; k < 100 && core_clk_en_out !== 1'b1; k++) @(posedge clk_in);
    irq_req_in <= 4'h0;
    chk("short recovery", 1, k >= 32 && k <= 40);
    complete_run();
  end
endmodule : cpu_core_state_and_flags_bench
